/* core/bqc_params.svh */
// Offsets, field positions, reset values and cycle counts of the biquad cascade core
`ifndef BQC_PARAMS_SVH
`define BQC_PARAMS_SVH
`define BQC_NUM_CH 16
`define BQC_NUM_STG 32
`define BQC_OFS_INPUT 12'h000
`define BQC_OFS_OUTPUT 12'h040
`define BQC_OFS_STATUS 12'h080
`define BQC_OFS_IRQ_EN 12'h0c0
`define BQC_OFS_STG_SEL 12'h100
`define BQC_OFS_CTRL 12'h140
`define BQC_OFS_ECC_FLAG 12'h144
`define BQC_OFS_ECC_IRQ_EN 12'h148
`define BQC_OFS_STG_MEM 12'h400
`define BQC_BIT_ORDY 0
`define BQC_BIT_PDONE 1
`define BQC_BIT_OPERR 2
`define BQC_BIT_ECC_SE 0
`define BQC_BIT_ECC_DE 1
`define BQC_BIT_RND_ZERO 0
`define BQC_SEL_FIRST_LSB 0
`define BQC_SEL_CNT_LSB 8
`define BQC_RST_FIRST 5'h00
`define BQC_RST_CNT 6'h01
`define BQC_CYC_PER_STAGE 2
`define BQC_WB_PER_STAGE 8'h05
`endif

/* core/bqc_pkg.sv */
// Types shared by the biquad cascade core
package bqc_pkg;
  typedef enum logic [3:0] {
    BQC_IDLE = 4'b0001,
    BQC_CALC_Y = 4'b0010,
    BQC_CALC_D = 4'b0100,
    BQC_WBACK = 4'b1000
  } bqc_state_t;
  typedef enum logic {
    BQC_RND_NEAREST = 1'b0,
    BQC_RND_ZERO = 1'b1
  } bqc_round_t;
endpackage

/* core/bqc_core.sv */
// Cascaded biquad IIR filter engine with its register port
//
// What this block does
// - Channels 0-2: own output-ready interrupt
// - Channels 3-15: one shared output-ready interrupt
// - Channels 0-2: own processing-done interrupt
// - Channels 3-15: one shared processing-done interrupt
// - Enabled operation error of any channel raises error interrupt
// - Enabled single-bit ECC flag raises error interrupt
// - Enabled double-bit ECC flag raises error interrupt
// - All data held as IEEE single precision
// - Compute wide, then round to single
// - Nearest mode: ties go to even
// - Toward-zero mode truncates every result
// - Input write starts channel's stages in order
// - Output ready flag and register before done
// - One channel job at a time
// - Input write during a job is stalled
// - Early output read stalls until ready
// - Read stall bounded, linear in stage count
// - Read after flag completes without wait
// - Two cycles per stage, five per stage for writeback
// - Denormals flush to signed zero, NaN to infinity
// - Pool of 32 stages shared by channels
// - Transposed direct form II, two delays
`timescale 1ns/10ps
`include "bqc_params.svh"
module bqc_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_wait_o,
  // Error reports from the coefficient memory protection
  input wire logic ecc_single_err_i,
  input wire logic ecc_double_err_i,
  // Interrupts
  output logic [2:0] chan_output_ready_irq_o,
  output logic shared_output_ready_irq_o,
  output logic [2:0] chan_proc_done_irq_o,
  output logic shared_proc_done_irq_o,
  output logic err_irq_o
);
  import bqc_pkg::*;

  // Flush denormals to signed zero and NaN to infinity
  function automatic logic [31:0] fp_clean(input logic [31:0] v);
    if (v[30:23] == 8'h00)
      fp_clean = {v[31], 31'h0};
    else if (v[30:23] == 8'hff)
      fp_clean = {v[31], 8'hff, 23'h0};
    else
      fp_clean = v;
  endfunction

  // m holds 24 mantissa bits, a round bit and a sticky bit
  function automatic logic [31:0] fp_pack(input logic s, input logic signed [11:0] e,
                                          input logic [25:0] m, input logic rz);
    logic inc;
    logic [24:0] r;
    logic signed [11:0] ef;
    inc = !rz && m[1] && (m[0] || m[2]);
    r = {1'b0, m[25:2]} + {24'h0, inc};
    ef = e;
    if (r[24])
    begin
      r = r >> 1;
      ef = e + 12'sd1;
    end
    if (ef >= 12'sd255)
      fp_pack = rz ? {s, 8'hfe, 23'h7fffff} : {s, 8'hff, 23'h0};
    else if (ef <= 12'sd0)
      fp_pack = {s, 31'h0};
    else
      fp_pack = {s, ef[7:0], r[22:0]};
  endfunction

  function automatic logic [31:0] fp_mul(input logic [31:0] a, input logic [31:0] b, input logic rz);
    logic s;
    logic [47:0] p;
    logic signed [11:0] e;
    s = a[31] ^ b[31];
    p = {24'h0, 1'b1, a[22:0]} * {24'h0, 1'b1, b[22:0]};
    e = $signed({4'h0, a[30:23]}) + $signed({4'h0, b[30:23]}) - 12'sd127;
    if (a[30:23] == 8'hff || b[30:23] == 8'hff)
      fp_mul = {s, 8'hff, 23'h0};
    else if (a[30:23] == 8'h00 || b[30:23] == 8'h00)
      fp_mul = {s, 31'h0};
    else if (p[47])
      fp_mul = fp_pack(s, e + 12'sd1, {p[47:24], p[23], |p[22:0]}, rz);
    else
      fp_mul = fp_pack(s, e, {p[46:23], p[22], |p[21:0]}, rz);
  endfunction

  function automatic logic [31:0] fp_add(input logic [31:0] a, input logic [31:0] b, input logic rz);
    logic [31:0] big;
    logic [31:0] sml;
    logic [7:0] d;
    logic [50:0] xa;
    logic [50:0] xb;
    logic [50:0] sum;
    logic [50:0] n;
    logic [5:0] lz;
    logic signed [11:0] e;
    big = (a[30:0] < b[30:0]) ? b : a;
    sml = (a[30:0] < b[30:0]) ? a : b;
    d = big[30:23] - sml[30:23];
    xa = {2'b01, big[22:0], 26'h0};
    xb = (d > 8'd26) ? 51'h1 : ({2'b01, sml[22:0], 26'h0} >> d);
    sum = (big[31] ^ sml[31]) ? xa - xb : xa + xb;
    lz = 6'd0;
    for (int i = 0; i < 51; i++)
      if (sum[i])
        lz = 6'(50 - i);
    n = sum << lz;
    e = $signed({4'h0, big[30:23]}) + 12'sd1 - $signed({6'h0, lz});
    if (big[30:23] == 8'hff)
      fp_add = big;
    else if (sml[30:23] == 8'h00)
      fp_add = (big[30:23] == 8'h00) ? {a[31] & b[31], 31'h0} : big;
    else if (sum == 51'h0)
      fp_add = 32'h0;
    else
      fp_add = fp_pack(big[31], e, {n[50:27], n[26], |n[25:0]}, rz);
  endfunction

  function automatic logic in_block(input logic [11:0] a, input logic [11:0] base);
    in_block = (a[11:6] == base[11:6]);
  endfunction

  function automatic logic [5:0] stg_count(input logic [5:0] f);
    stg_count = (f == 6'h0) ? 6'h1 : (f > 6'd32) ? 6'd32 : f;
  endfunction

  bqc_state_t state;
  logic [3:0] cur_ch;
  logic [4:0] stg_idx;
  logic [5:0] stg_left;
  logic [5:0] job_cnt;
  logic [7:0] wb_cnt;
  logic [31:0] x_cur;
  logic [31:0] y_reg;
  logic [31:0] stage_mem [0:255];
  logic [31:0] in_reg [0:15];
  logic [31:0] out_reg [0:15];
  logic [4:0] sel_first [0:15];
  logic [5:0] sel_cnt [0:15];
  logic [15:0] ordy_flag;
  logic [15:0] pdone_flag;
  logic [15:0] operr_flag;
  logic [15:0] ordy_en;
  logic [15:0] pdone_en;
  logic [15:0] operr_en;
  logic [1:0] ecc_flag;
  logic [1:0] ecc_en;
  logic rnd_mode;

  // Bus decode
  wire [3:0] bus_ch = reg_addr_i[5:2];
  wire [15:0] ch_dec = 16'h1 << bus_ch;
  wire [15:0] job_dec = 16'h1 << cur_ch;
  wire busy = (state != BQC_IDLE);
  wire hit_in = in_block(reg_addr_i, `BQC_OFS_INPUT);
  wire hit_out = in_block(reg_addr_i, `BQC_OFS_OUTPUT);
  wire hit_sts = in_block(reg_addr_i, `BQC_OFS_STATUS);
  wire hit_ien = in_block(reg_addr_i, `BQC_OFS_IRQ_EN);
  wire hit_sel = in_block(reg_addr_i, `BQC_OFS_STG_SEL);
  wire hit_ctrl = (reg_addr_i == `BQC_OFS_CTRL);
  wire hit_eccf = (reg_addr_i == `BQC_OFS_ECC_FLAG);
  wire hit_ecce = (reg_addr_i == `BQC_OFS_ECC_IRQ_EN);
  wire hit_mem = (reg_addr_i[11:10] == 2'(`BQC_OFS_STG_MEM >> 10));
  wire stall_wr = reg_wr_i && hit_in && busy;
  wire stall_rd = reg_rd_i && hit_out && busy && (cur_ch == bus_ch) && !ordy_flag[bus_ch];
  wire wr_ok = reg_wr_i && !stall_wr;
  wire rd_ok = reg_rd_i && !stall_rd;
  wire start = wr_ok && hit_in;

  // Datapath: one stage of transposed direct form II
  wire rz = (rnd_mode == BQC_RND_ZERO);
  wire [31:0] c_b0 = fp_clean(stage_mem[{stg_idx, 3'd0}]);
  wire [31:0] c_b1 = fp_clean(stage_mem[{stg_idx, 3'd1}]);
  wire [31:0] c_b2 = fp_clean(stage_mem[{stg_idx, 3'd2}]);
  wire [31:0] c_a1 = fp_clean(stage_mem[{stg_idx, 3'd3}]);
  wire [31:0] c_a2 = fp_clean(stage_mem[{stg_idx, 3'd4}]);
  wire [31:0] c_d1 = fp_clean(stage_mem[{stg_idx, 3'd5}]);
  wire [31:0] c_d2 = fp_clean(stage_mem[{stg_idx, 3'd6}]);
  wire [31:0] y_calc = fp_add(fp_mul(c_b0, x_cur, rz), c_d1, rz);
  wire [31:0] d1_calc = fp_add(fp_add(fp_mul(c_b1, x_cur, rz), fp_mul(c_a1, y_reg, rz), rz), c_d2, rz);
  wire [31:0] d2_calc = fp_add(fp_mul(c_b2, x_cur, rz), fp_mul(c_a2, y_reg, rz), rz);
  wire st_y = (state == BQC_CALC_Y);
  wire st_d = (state == BQC_CALC_D);
  wire last = st_d && (stg_left == 6'h1);
  wire finish = (state == BQC_WBACK) && (wb_cnt == 8'h0);
  wire calc_err = (st_y && y_calc[30:23] == 8'hff) ||
                  (st_d && (d1_calc[30:23] == 8'hff || d2_calc[30:23] == 8'hff));
  wire [7:0] wb_load = 8'({2'b00, job_cnt} * `BQC_WB_PER_STAGE - 8'h1);

  // Flag updates: a hardware set wins over a clear in the same cycle
  wire sts_wr = wr_ok && hit_sts;
  wire [15:0] start_clr = start ? ch_dec : 16'h0;
  wire [15:0] next_ordy = (ordy_flag & ~((sts_wr && reg_wdata_i[`BQC_BIT_ORDY]) ? ch_dec : 16'h0)
                          & ~start_clr) | (last ? job_dec : 16'h0);
  wire [15:0] next_pdone = (pdone_flag & ~((sts_wr && reg_wdata_i[`BQC_BIT_PDONE]) ? ch_dec : 16'h0)
                           & ~start_clr) | (finish ? job_dec : 16'h0);
  wire [15:0] next_operr = (operr_flag & ~((sts_wr && reg_wdata_i[`BQC_BIT_OPERR]) ? ch_dec : 16'h0)
                           & ~start_clr) | (calc_err ? job_dec : 16'h0);
  wire ecc_wr = wr_ok && hit_eccf;
  wire [1:0] ecc_clr = ecc_wr ? {reg_wdata_i[`BQC_BIT_ECC_DE], reg_wdata_i[`BQC_BIT_ECC_SE]} : 2'b00;
  wire [1:0] next_ecc = (ecc_flag & ~ecc_clr) | {ecc_double_err_i, ecc_single_err_i};

  // Interrupts
  wire [15:0] ordy_act = ordy_flag & ordy_en;
  wire [15:0] pdone_act = pdone_flag & pdone_en;
  assign chan_output_ready_irq_o = ordy_act[2:0];
  assign shared_output_ready_irq_o = |ordy_act[15:3];
  assign chan_proc_done_irq_o = pdone_act[2:0];
  assign shared_proc_done_irq_o = |pdone_act[15:3];
  assign err_irq_o = (|(operr_flag & operr_en))
                     || (ecc_flag[`BQC_BIT_ECC_SE] && ecc_en[`BQC_BIT_ECC_SE])
                     || (ecc_flag[`BQC_BIT_ECC_DE] && ecc_en[`BQC_BIT_ECC_DE]);
  assign reg_wait_o = stall_wr || stall_rd;

  // Read selection
  wire [31:0] rd_sts = {29'h0, operr_flag[bus_ch], pdone_flag[bus_ch], ordy_flag[bus_ch]};
  wire [31:0] rd_ien = {29'h0, operr_en[bus_ch], pdone_en[bus_ch], ordy_en[bus_ch]};
  wire [31:0] rd_sel = {18'h0, sel_cnt[bus_ch], 3'h0, sel_first[bus_ch]};
  wire [31:0] next_rdata = !rd_ok ? 32'h0 :
                           hit_in ? in_reg[bus_ch] :
                           hit_out ? out_reg[bus_ch] :
                           hit_sts ? rd_sts :
                           hit_ien ? rd_ien :
                           hit_sel ? rd_sel :
                           hit_ctrl ? {31'h0, rnd_mode} :
                           hit_eccf ? {30'h0, ecc_flag} :
                           hit_ecce ? {30'h0, ecc_en} :
                           hit_mem ? stage_mem[reg_addr_i[9:2]] : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h0;
    else
      reg_rdata_o <= next_rdata;
  end

  // Shared stage pool: coefficients b0 b1 b2 a1 a2, then delays d1 d2
  always_ff @(posedge clk_i)
  begin
    if (wr_ok && hit_mem)
      stage_mem[reg_addr_i[9:2]] <= reg_wdata_i;
    if (st_d)
    begin
      stage_mem[{stg_idx, 3'd5}] <= d1_calc;
      stage_mem[{stg_idx, 3'd6}] <= d2_calc;
    end
  end

  // Per-channel sample and stage-selection registers
  for (genvar c = 0; c < `BQC_NUM_CH; c++)
  begin : g_ch
    always_ff @(posedge clk_i)
    begin
      if (sys_rst_i)
      begin
        in_reg[c] <= 32'h0;
        out_reg[c] <= 32'h0;
        sel_first[c] <= `BQC_RST_FIRST;
        sel_cnt[c] <= `BQC_RST_CNT;
      end
      else
      begin
        if (start && ch_dec[c])
          in_reg[c] <= reg_wdata_i;
        if (last && job_dec[c])
          out_reg[c] <= y_reg;
        if (wr_ok && hit_sel && ch_dec[c])
        begin
          sel_first[c] <= reg_wdata_i[`BQC_SEL_FIRST_LSB +: 5];
          sel_cnt[c] <= reg_wdata_i[`BQC_SEL_CNT_LSB +: 6];
        end
      end
    end
  end

  // Flags, enables and control
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ordy_flag <= 16'h0;
      pdone_flag <= 16'h0;
      operr_flag <= 16'h0;
      ordy_en <= 16'h0;
      pdone_en <= 16'h0;
      operr_en <= 16'h0;
      ecc_flag <= 2'b00;
      ecc_en <= 2'b00;
      rnd_mode <= BQC_RND_NEAREST;
    end
    else
    begin
      ordy_flag <= next_ordy;
      pdone_flag <= next_pdone;
      operr_flag <= next_operr;
      ecc_flag <= next_ecc;
      if (wr_ok && hit_ien)
      begin
        ordy_en[bus_ch] <= reg_wdata_i[`BQC_BIT_ORDY];
        pdone_en[bus_ch] <= reg_wdata_i[`BQC_BIT_PDONE];
        operr_en[bus_ch] <= reg_wdata_i[`BQC_BIT_OPERR];
      end
      if (wr_ok && hit_ecce)
        ecc_en <= reg_wdata_i[1:0];
      if (wr_ok && hit_ctrl)
        rnd_mode <= reg_wdata_i[`BQC_BIT_RND_ZERO];
    end
  end

  // Job sequencer: stages in order, then state writeback
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= BQC_IDLE;
      cur_ch <= 4'h0;
      stg_idx <= 5'h0;
      stg_left <= 6'h0;
      job_cnt <= 6'h0;
      wb_cnt <= 8'h0;
      x_cur <= 32'h0;
      y_reg <= 32'h0;
    end
    else
    begin
      unique case (state)
        BQC_IDLE:
        begin
          if (start)
          begin
            cur_ch <= bus_ch;
            stg_idx <= sel_first[bus_ch];
            stg_left <= stg_count(sel_cnt[bus_ch]);
            job_cnt <= stg_count(sel_cnt[bus_ch]);
            x_cur <= fp_clean(reg_wdata_i);
            state <= BQC_CALC_Y;
          end
        end
        BQC_CALC_Y:
        begin
          y_reg <= y_calc;
          state <= BQC_CALC_D;
        end
        BQC_CALC_D:
        begin
          x_cur <= y_reg;
          stg_idx <= stg_idx + 5'h1;
          stg_left <= stg_left - 6'h1;
          if (last)
          begin
            wb_cnt <= wb_load;
            state <= BQC_WBACK;
          end
          else
            state <= BQC_CALC_Y;
        end
        BQC_WBACK:
        begin
          wb_cnt <= wb_cnt - 8'h1;
          if (wb_cnt == 8'h0)
            state <= BQC_IDLE;
        end
        default:
          state <= BQC_IDLE;
      endcase
    end
  end
endmodule

/* tb/bqc_checker.sv */
// Port assertions of the biquad cascade core
`timescale 1ns/10ps
module bqc_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wait_o,
  // ECC and interrupts
  input wire logic ecc_single_err_i,
  input wire logic ecc_double_err_i,
  input wire logic [2:0] chan_proc_done_irq_o,
  input wire logic err_irq_o
);
  logic [1:0] ecc_en;
  wire logic en_wr = reg_wr_i && !reg_wait_o && reg_addr_i == 12'h148;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ecc_en <= 2'h0;
    else if (en_wr)
      ecc_en <= reg_wdata_i[1:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_wr_stall_input: assert property (reg_wait_o && reg_wr_i |-> reg_addr_i < 12'h040)
    else $error("stall on a write that is no input write");
  a_rd_stall_output: assert property (reg_wait_o && reg_rd_i |-> reg_addr_i inside {[12'h040:12'h07f]})
    else $error("stall on a read that is no output read");
  a_rd_stall_bound: assert property ($rose(reg_wait_o) && reg_rd_i |-> ##[1:66] !reg_wait_o)
    else $error("output read stalled too long");
  a_wr_stall_bound: assert property ($rose(reg_wait_o) && reg_wr_i |-> ##[1:230] !reg_wait_o)
    else $error("input write stalled too long");
  a_ecc_single_irq: assert property (ecc_single_err_i && ecc_en[0] |=> err_irq_o)
    else $error("single-bit ECC error gave no interrupt");
  a_ecc_double_irq: assert property (ecc_double_err_i && ecc_en[1] |=> err_irq_o)
    else $error("double-bit ECC error gave no interrupt");
  a_err_irq_holds: assert property (err_irq_o && !reg_wr_i |=> err_irq_o)
    else $error("error interrupt fell without a write");
  a_done_irq_holds: assert property (!reg_wr_i |=>
    (chan_proc_done_irq_o & $past(chan_proc_done_irq_o)) == $past(chan_proc_done_irq_o))
    else $error("done interrupt fell without a write");
endmodule

/* tb/bqc_bus_master.sv */
// Bus master model driving the register port
`timescale 1ns/10ps
module bqc_bus_master (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [11:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [31:0] reg_rdata_i,
  input wire logic reg_wait_i
);
  int waits;
  initial
  begin
    reg_addr_o = 12'h000;
    reg_wdata_o = 32'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Held until the stall drops; waits counts the stalled cycles
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    logic w;
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= wr;
    reg_rd_o <= !wr;
    waits = 0;
    w = 1'b1;
    while (w)
    begin
      @(negedge clk_i);
      w = reg_wait_i;
      @(posedge clk_i);
      if (w)
        waits++;
    end
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    // Released data lines toggle so stale values are never mistaken
    reg_wdata_o <= ~d;
    @(negedge clk_i);
    q = reg_rdata_i;
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the biquad cascade core
`timescale 1ns/10ps
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ecc_se = 1'b0;
  logic ecc_de = 1'b0;
  wire logic [11:0] addr;
  wire logic [31:0] wdata, rdata;
  wire logic wr, rd, stall, err_irq, sh_rdy, sh_done;
  wire logic [2:0] ch_rdy, ch_done;
  logic [31:0] q, x;
  logic [31:0] ct [6][4];
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 85;
  int cyc = 0;
  int ch, n;
  bqc_core u_bqc_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_wait_o(stall), .ecc_single_err_i(ecc_se),
    .ecc_double_err_i(ecc_de), .chan_output_ready_irq_o(ch_rdy), .shared_output_ready_irq_o(sh_rdy),
    .chan_proc_done_irq_o(ch_done), .shared_proc_done_irq_o(sh_done), .err_irq_o(err_irq));
  bqc_bus_master u_bqc_bus_master (.clk_i(clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_wait_i(stall));
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    u_bqc_bus_master.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_reg(input logic [11:0] a);
    u_bqc_bus_master.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    n_tests++;
    if (v < lo || v > hi)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: stall %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] irq_exp(input int c, input logic [2:0] f);
    logic [31:0] v;
    v = {23'h0, f[2], 8'h0};
    v[c < 3 ? c : 3] = f[0];
    v[c < 3 ? c + 4 : 7] = f[1];
    return v;
  endfunction
  // One job, then a second one back to back and a third one on the same channel
  task automatic job(input int c, input int first, input int k, input logic [31:0] xi, input logic [31:0] exp);
    int t;
    logic [11:0] o;
    t = 0;
    o = 12'(4 * c);
    wr_reg(12'h100 + o, {18'h0, 6'(k), 3'h0, 5'(first)});
    wr_reg(12'h0c0 + o, 32'h7);
    wr_reg(o, xi);
    rd_reg(12'h040 + o);
    chk(q, exp);
    chk_rng(u_bqc_bus_master.waits, 1, 2 * k);
    wr_reg(o, xi);
    chk_rng(u_bqc_bus_master.waits, 1, 7 * k + 3);
    rd_reg(12'h080 + o);
    while (q[1] !== 1'b1 && t < 300)
    begin
      rd_reg(12'h080 + o);
      t++;
    end
    chk(q, {29'h0, exp[30:23] == 8'hff, 2'h3});
    chk({23'h0, err_irq, sh_done, ch_done, sh_rdy, ch_rdy}, irq_exp(c, {exp[30:23] == 8'hff, 2'b11}));
    rd_reg(12'h040 + o);
    chk(q, exp);
    chk_rng(u_bqc_bus_master.waits, 0, 0);
    // Third sample served by interrupts: read on ready, then wait for done
    wr_reg(o, xi);
    t = 0;
    while ((32'({sh_rdy, ch_rdy}) & irq_exp(c, 3'h1)) == 32'h0 && t < 300)
    begin
      @(negedge clk_i);
      t++;
    end
    chk_rng(t, 1, 2 * k);
    rd_reg(12'h040 + o);
    chk(q, exp);
    chk_rng(u_bqc_bus_master.waits, 0, 0);
    t = 0;
    while (((32'({sh_done, ch_done}) << 4) & irq_exp(c, 3'h2)) == 32'h0 && t < 300)
    begin
      @(negedge clk_i);
      t++;
    end
    chk_rng(t, 1, 7 * k);
    wr_reg(12'h0c0 + o, 32'h0);
    chk({23'h0, err_irq, sh_done, ch_done, sh_rdy, ch_rdy}, 32'h0);
    wr_reg(12'h080 + o, 32'h7);
    wr_reg(12'h0c0 + o, 32'h7);
    chk({23'h0, err_irq, sh_done, ch_done, sh_rdy, ch_rdy}, 32'h0);
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      conclude();
    end
  end
  initial
  begin
    ct = '{'{32'h3fc00001, 32'h3fc00001, 0, 32'h40100002}, '{32'h3fc00001, 32'h3fc00001, 1, 32'h40100001},
      '{32'h3fc00000, 32'h3f800001, 0, 32'h3fc00002}, '{32'h3fc00000, 32'h3f800001, 1, 32'h3fc00001},
      '{32'h40000000, 32'h00000001, 0, 32'h0}, '{32'h40000000, 32'h7fc00001, 0, 32'h7f800000}};
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_reg(12'h140);
    chk(q, 32'h0);
    rd_reg(12'h114);
    chk(q, 32'h100);
    rd_reg(12'h3f0);
    chk(q, 32'h0);
    for (int s = 0; s < 224; s++)
      wr_reg(12'h400 + 12'(s / 7 * 32 + s % 7 * 4), s % 7 == 0 ? 32'h40000000 : 32'h0);
    job(3, 31, 32, 32'h3f800000, 32'h4f800000);
    repeat (12)
    begin
      ch = $unsigned($random(seed)) % 16;
      n = 1 + $unsigned($random(seed)) % 32;
      x = $random(seed);
      x[30:23] = 8'(1 + $unsigned($random(seed)) % (254 - n));
      job(ch, $unsigned($random(seed)) % 32, n, x, {x[31], x[30:23] + 8'(n), x[22:0]});
    end
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(12'h400, ct[i][0]);
      wr_reg(12'h140, ct[i][2]);
      job(i, 0, 1, ct[i][1], ct[i][3]);
    end
    for (int b = 0; b < 4; b++)
    begin
      wr_reg(12'h148, b < 2 ? 32'h3 : 32'h0);
      @(posedge clk_i);
      ecc_se <= b % 2 == 0;
      ecc_de <= b % 2 == 1;
      @(posedge clk_i);
      ecc_se <= 1'b0;
      ecc_de <= 1'b0;
      @(negedge clk_i);
      chk({31'h0, err_irq}, {31'h0, b < 2});
      wr_reg(12'h144, 32'h3);
      chk({31'h0, err_irq}, 32'h0);
    end
    conclude();
  end
endmodule
bind bqc_core bqc_checker u_bqc_checker (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_wait_o, .ecc_single_err_i, .ecc_double_err_i, .chan_proc_done_irq_o, .err_irq_o);
